// *** rtl/ssso_core.sv ***
// How it works
// - nonzero skip rewrites the byte it read
// - skip next instruction when byte nonzero
// - taken skip adds one dummy cycle
// - register minus memory into working register
// - carry clear on negative, else set
// - subtracts update all six status flags
// - register minus memory written to memory
// - register minus immediate into working register
// - swap memory byte nibbles in place
`timescale 1ns/1ps
module ssso_core
   import ssso_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // instruction issue
   input wire logic ins_valid,
   input wire ssso_pkg::ssso_op_t ins_op,
   input wire logic [7:0] ins_addr,
   input wire logic [7:0] ins_imm,
   output logic ins_ready,
   // data memory preload
   input wire logic load_valid,
   input wire logic [7:0] load_addr,
   input wire logic [7:0] load_data,
   // results
   output logic done,
   output logic skip,
   output logic dummy,
   output logic [7:0] working_register,
   output logic [7:0] mem_result,
   output logic carry_flag,
   output logic aux_carry_flag,
   output logic zero_flag,
   output logic signed_excess_flag,
   output logic signed_compare_flag,
   output logic chained_zero_flag
);
   import ssso_pkg::*;

   ssso_mem_if mbus ();

   ssso_dmem u_dmem (
      .mclk(mclk),
      .mp(mbus.mem)
   );

   ssso_state_t state_r;
   ssso_state_t state_nxt;
   ssso_op_t op_r;
   logic [7:0] addr_r;
   logic [7:0] imm_r;
   logic ready_r;
   logic done_r;
   logic skip_r;
   logic dummy_r;
   logic [7:0] wreg_r;
   logic [7:0] wreg_nxt;
   logic [7:0] memres_r;
   logic [SSSO_NFLAGS-1:0] flags_r;
   logic [SSSO_NFLAGS-1:0] flags_nxt;

   logic take;
   logic load_take;
   logic is_sub;
   logic [7:0] sub_b;
   logic [8:0] diff9;
   logic [4:0] diff5;
   logic [7:0] diff;
   logic [7:0] swapped;
   logic skip_taken;
   logic wr_back;
   logic [7:0] wr_data;

   assign take = (state_r == SSSO_S_IDLE) && ins_valid;
   // an instruction wins the memory port over a preload in the same cycle
   assign load_take = (state_r == SSSO_S_IDLE) && load_valid && !ins_valid;

   // subtract datapath shared by all three forms
   assign is_sub = (op_r == SSSO_OP_SUB_MEM) || (op_r == SSSO_OP_SUB_TO_MEM)
                   || (op_r == SSSO_OP_SUB_IMM);
   assign sub_b = (op_r == SSSO_OP_SUB_IMM) ? imm_r : mbus.rdata;
   assign diff9 = {1'b0, wreg_r} - {1'b0, sub_b};
   assign diff5 = {1'b0, wreg_r[3:0]} - {1'b0, sub_b[3:0]};
   assign diff = diff9[7:0];
   assign swapped = {mbus.rdata[SSSO_NIB-1:0], mbus.rdata[SSSO_DW-1:SSSO_NIB]};
   assign skip_taken = (op_r == SSSO_OP_SKIP_NZ) && (mbus.rdata != SSSO_ZERO_BYTE);

   // flag values for a subtract; borrow out means a negative result
   always_comb begin
      flags_nxt = flags_r;
      if (is_sub) begin
         flags_nxt[SSSO_F_CARRY] = !diff9[8];
         flags_nxt[SSSO_F_AUX] = !diff5[4];
         flags_nxt[SSSO_F_ZERO] = (diff == SSSO_ZERO_BYTE);
         flags_nxt[SSSO_F_OVF] = (wreg_r[7] != sub_b[7]) && (diff[7] != wreg_r[7]);
         // signed compare: set when the signed difference is negative
         flags_nxt[SSSO_F_SC] = diff[7] ^ flags_nxt[SSSO_F_OVF];
         // an unchained subtract loads the chained zero with plain zero
         flags_nxt[SSSO_F_CZ] = flags_nxt[SSSO_F_ZERO];
      end
   end

   // memory write-back in the execute cycle
   always_comb begin
      wr_back = 1'b0;
      wr_data = mbus.rdata;
      case (op_r)
         SSSO_OP_SKIP_NZ: begin
            wr_back = 1'b1;
            wr_data = mbus.rdata;
         end
         SSSO_OP_SUB_TO_MEM: begin
            wr_back = 1'b1;
            wr_data = diff;
         end
         SSSO_OP_SWAP: begin
            wr_back = 1'b1;
            wr_data = swapped;
         end
         default: begin
            wr_back = 1'b0;
            wr_data = mbus.rdata;
         end
      endcase
   end

   always_comb begin
      wreg_nxt = wreg_r;
      if ((op_r == SSSO_OP_SUB_MEM) || (op_r == SSSO_OP_SUB_IMM)) begin
         wreg_nxt = diff;
      end
   end

   // memory port: preload, operand read, or write-back
   always_comb begin
      mbus.we = 1'b0;
      mbus.addr = addr_r;
      mbus.wdata = wr_data;
      if (load_take) begin
         mbus.we = 1'b1;
         mbus.addr = load_addr;
         mbus.wdata = load_data;
      end else if (state_r == SSSO_S_EXEC) begin
         mbus.we = wr_back;
      end
   end

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         SSSO_S_IDLE: begin
            if (take) begin
               state_nxt = SSSO_S_READ;
            end
         end
         SSSO_S_READ: state_nxt = SSSO_S_EXEC;
         SSSO_S_EXEC: begin
            state_nxt = skip_taken ? SSSO_S_DUMMY : SSSO_S_IDLE;
         end
         SSSO_S_DUMMY: state_nxt = SSSO_S_IDLE;
         default: state_nxt = SSSO_S_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         state_r <= SSSO_S_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // instruction latch
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         op_r <= SSSO_OP_PEEK;
         addr_r <= 8'h00;
         imm_r <= 8'h00;
      end else if (take) begin
         op_r <= ins_op;
         addr_r <= ins_addr;
         imm_r <= ins_imm;
      end
   end

   // ready reasserts only once the core is back in idle
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ready_r <= 1'b1;
      end else begin
         ready_r <= (state_nxt == SSSO_S_IDLE);
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         done_r <= 1'b0;
         skip_r <= 1'b0;
         dummy_r <= 1'b0;
      end else begin
         done_r <= (state_r == SSSO_S_EXEC);
         skip_r <= (state_r == SSSO_S_EXEC) && skip_taken;
         dummy_r <= (state_nxt == SSSO_S_DUMMY);
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wreg_r <= SSSO_WREG_RST;
         flags_r <= SSSO_FLAGS_RST;
         memres_r <= 8'h00;
      end else if (state_r == SSSO_S_EXEC) begin
         wreg_r <= wreg_nxt;
         flags_r <= flags_nxt;
         memres_r <= wr_back ? wr_data : mbus.rdata;
      end
   end

   assign ins_ready = ready_r;
   assign done = done_r;
   assign skip = skip_r;
   assign dummy = dummy_r;
   assign working_register = wreg_r;
   assign mem_result = memres_r;
   assign carry_flag = flags_r[SSSO_F_CARRY];
   assign aux_carry_flag = flags_r[SSSO_F_AUX];
   assign zero_flag = flags_r[SSSO_F_ZERO];
   assign signed_excess_flag = flags_r[SSSO_F_OVF];
   assign signed_compare_flag = flags_r[SSSO_F_SC];
   assign chained_zero_flag = flags_r[SSSO_F_CZ];
endmodule // ssso_core

// *** rtl/ssso_dmem.sv ***
`timescale 1ns/1ps
module ssso_dmem
   import ssso_pkg::*;
(
   // clock
   input wire logic mclk,
   // port
   ssso_mem_if.mem mp
);
   logic [SSSO_DW-1:0] mem_r [SSSO_DEPTH];

   // no reset on the array: contents are undefined until written
   always_ff @(posedge mclk) begin
      if (mp.we) begin
         mem_r[mp.addr] <= mp.wdata;
      end
   end

   // read data always registered; a same-cycle write returns the old byte
   always_ff @(posedge mclk) begin
      mp.rdata <= mem_r[mp.addr];
   end
endmodule // ssso_dmem

// *** shared/ssso_mem_if.sv ***
`timescale 1ns/1ps
interface ssso_mem_if;
   logic we;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;

   modport core (
      output we,
      output addr,
      output wdata,
      input rdata
   );

   modport mem (
      input we,
      input addr,
      input wdata,
      output rdata
   );
endinterface

// *** shared/ssso_pkg.sv ***
package ssso_pkg;

   localparam int SSSO_DW = 8;
   localparam int SSSO_AW = 8;
   localparam int SSSO_DEPTH = 256;
   localparam int SSSO_NIB = 4;

   // byte values used by the skip test and the reset state
   localparam logic [7:0] SSSO_ZERO_BYTE = 8'h00;
   localparam logic [7:0] SSSO_WREG_RST = 8'h00;

   // flag vector positions
   localparam int SSSO_F_CARRY = 0;
   localparam int SSSO_F_AUX = 1;
   localparam int SSSO_F_ZERO = 2;
   localparam int SSSO_F_OVF = 3;
   localparam int SSSO_F_SC = 4;
   localparam int SSSO_F_CZ = 5;
   localparam int SSSO_NFLAGS = 6;
   localparam logic [5:0] SSSO_FLAGS_RST = 6'h00;

   // extra cycles after the execute cycle when a skip is taken
   localparam int SSSO_SKIP_DUMMY = 1;

   typedef enum logic [2:0] {
      SSSO_OP_SKIP_NZ = 3'h0,
      SSSO_OP_SUB_MEM = 3'h1,
      SSSO_OP_SUB_TO_MEM = 3'h2,
      SSSO_OP_SUB_IMM = 3'h3,
      SSSO_OP_SWAP = 3'h4,
      SSSO_OP_PEEK = 3'h5
   } ssso_op_t;

   typedef enum logic [1:0] {
      SSSO_S_IDLE = 2'b00,
      SSSO_S_READ = 2'b01,
      SSSO_S_EXEC = 2'b10,
      SSSO_S_DUMMY = 2'b11
   } ssso_state_t;

endpackage

// *** test/ssso_core_properties.sv ***
`timescale 1ns/1ps
module ssso_core_properties (
   // clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // handshake and results
   input wire logic ins_valid,
   input wire logic ins_ready,
   input wire logic done,
   input wire logic skip,
   input wire logic dummy,
   input wire logic [7:0] working_register,
   input wire logic carry_flag,
   input wire logic aux_carry_flag,
   input wire logic zero_flag,
   input wire logic signed_excess_flag,
   input wire logic signed_compare_flag,
   input wire logic chained_zero_flag
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   wire [5:0] flags = {chained_zero_flag, signed_compare_flag, signed_excess_flag,
      zero_flag, aux_carry_flag, carry_flag};
   a_take_answer: assert property (ins_valid && ins_ready |=> !ins_ready ##1 !done ##1 done)
      else $error("done not two cycles after take");
   a_done_pulse: assert property (done |=> !done)
      else $error("done longer than one cycle");
   a_skip_dummy: assert property (skip |-> done && dummy && !ins_ready)
      else $error("skip without done or dummy");
   a_skip_release: assert property (skip |=> ins_ready && !dummy && !skip)
      else $error("skip did not end after one dummy cycle");
   a_dummy_cause: assert property (dummy |-> skip)
      else $error("dummy without skip");
   a_ready_plain: assert property (done && !skip |-> ins_ready)
      else $error("not ready after plain completion");
   a_flags_hold: assert property (!done |-> $stable(flags))
      else $error("flags moved outside completion");
   a_wreg_hold: assert property (!done |-> $stable(working_register))
      else $error("working register moved outside completion");
   a_cz_zero: assert property (chained_zero_flag == zero_flag)
      else $error("chained zero differs from zero");
   a_carry_zero: assert property (zero_flag |-> carry_flag)
      else $error("zero result with borrow");
endmodule // ssso_core_properties

// *** test/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
   import ssso_pkg::*;
   logic mclk = 0, nrst = 0, ins_valid = 0, load_valid = 0;
   ssso_op_t ins_op = SSSO_OP_PEEK;
   logic [7:0] ins_addr = 8'h00, ins_imm = 8'h00, load_addr = 8'h00, load_data = 8'h00;
   logic ins_ready, done, skip, dummy, carry_flag, aux_carry_flag, zero_flag;
   logic signed_excess_flag, signed_compare_flag, chained_zero_flag;
   logic [7:0] working_register, mem_result, wm;
   logic [7:0] mem [0:16];
   int n_errors = 0, checks = 0;
   wire [5:0] flags = {chained_zero_flag, signed_compare_flag, signed_excess_flag,
      zero_flag, aux_carry_flag, carry_flag};
   ssso_core ssso_core_inst (
      .mclk(mclk), .nrst(nrst), .ins_valid(ins_valid), .ins_op(ins_op),
      .ins_addr(ins_addr), .ins_imm(ins_imm), .ins_ready(ins_ready),
      .load_valid(load_valid), .load_addr(load_addr), .load_data(load_data),
      .done(done), .skip(skip), .dummy(dummy), .working_register(working_register),
      .mem_result(mem_result), .carry_flag(carry_flag), .aux_carry_flag(aux_carry_flag),
      .zero_flag(zero_flag), .signed_excess_flag(signed_excess_flag),
      .signed_compare_flag(signed_compare_flag), .chained_zero_flag(chained_zero_flag)
   );
   always #4 mclk = ~mclk;
   function automatic logic [5:0] sub_flags(input logic [7:0] w, input logic [7:0] s);
      logic [7:0] r;
      logic ov;
      r = w - s;
      ov = (w[7] != s[7]) && (r[7] != w[7]);
      return {r == 8'h00, r[7] ^ ov, ov, r == 8'h00, w[3:0] >= s[3:0], w >= s};
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic load(input logic [7:0] a, input logic [7:0] d);
      load_valid = 1;
      load_addr = a;
      load_data = d;
      mem[a] = d;
      // load_valid stays up between back-to-back preloads; the caller drops it
      @(posedge mclk);
      #1;
   endtask
   task automatic exec(input ssso_op_t op, input logic [7:0] a, input logic [7:0] imm);
      logic [7:0] m, s;
      logic [5:0] fm;
      logic sk;
      m = mem[a];
      s = (op == SSSO_OP_SUB_IMM) ? imm : m;
      sk = (op == SSSO_OP_SKIP_NZ) && (m != SSSO_ZERO_BYTE);
      fm = flags;
      ins_valid = 1;
      ins_op = op;
      ins_addr = a;
      ins_imm = imm;
      @(posedge mclk);
      #1 ins_valid = 0;
      ins_imm = 8'($urandom);
      repeat (2) @(posedge mclk);
      #1;
      chk(done, 1'b1);
      chk(skip, sk);
      chk(dummy, sk);
      case (op)
         SSSO_OP_SKIP_NZ, SSSO_OP_PEEK: chk(mem_result, m);
         SSSO_OP_SWAP: mem[a] = {m[3:0], m[7:4]};
         SSSO_OP_SUB_TO_MEM: mem[a] = wm - m;
         default: wm = wm - s;
      endcase
      if (op inside {SSSO_OP_SUB_MEM, SSSO_OP_SUB_TO_MEM, SSSO_OP_SUB_IMM}) begin
         fm = sub_flags(wm, s);
      end
      if (op inside {SSSO_OP_SWAP, SSSO_OP_SUB_TO_MEM}) chk(mem_result, mem[a]);
      if (op == SSSO_OP_SUB_MEM || op == SSSO_OP_SUB_IMM) begin
         fm = sub_flags(wm + s, s);
      end
      chk(working_register, wm);
      chk({2'h0, flags}, {2'h0, fm});
      if (sk) begin
         repeat (SSSO_SKIP_DUMMY) @(posedge mclk);
         #1;
      end
      chk(ins_ready, 1'b1);
   endtask
   bit [7:0] kat_imm [4] = '{8'h00, 8'h00, 8'h7F, 8'h01};
   ssso_op_t kat_op [4] = '{SSSO_OP_SUB_IMM, SSSO_OP_SUB_MEM, SSSO_OP_SUB_IMM, SSSO_OP_SUB_IMM};
   initial begin
      #100000;
      n_errors++;
      results();
   end
   initial begin
      void'($urandom(32'h32529EA6));
      wm = SSSO_WREG_RST;
      repeat (16) @(posedge mclk);
      #1 nrst = 1;
      // low addresses hold zero so the skip falls through often
      for (int a = 0; a < 16; a++) load(a[7:0], (a < 4) ? 8'h00 : 8'($urandom));
      load(8'h10, 8'h01);
      load_valid = 0;
      // zero result, borrow, plain negative, signed overflow
      for (int i = 0; i < 4; i++) exec(kat_op[i], 8'h10, kat_imm[i]);
      exec(SSSO_OP_SKIP_NZ, 8'h10, 8'h00);
      exec(SSSO_OP_SKIP_NZ, 8'h00, 8'h00);
      for (int i = 0; i < 400; i++)
         exec(ssso_op_t'($urandom_range(5, 0)), 8'($urandom_range(16, 0)), 8'($urandom));
      for (int a = 0; a < 17; a++) exec(SSSO_OP_PEEK, a[7:0], 8'h00);
      results();
   end
endmodule // tb_top
bind ssso_core ssso_core_properties ssso_core_properties_inst (
   .mclk(mclk), .nrst(nrst), .ins_valid(ins_valid), .ins_ready(ins_ready),
   .done(done), .skip(skip), .dummy(dummy), .working_register(working_register),
   .carry_flag(carry_flag), .aux_carry_flag(aux_carry_flag), .zero_flag(zero_flag),
   .signed_excess_flag(signed_excess_flag), .signed_compare_flag(signed_compare_flag),
   .chained_zero_flag(chained_zero_flag)
);
